/* File: include/dpq_regs.svh */
/*
 * Register offsets, field positions, reset values and command codes of the
 * disk power query and configuration restore block.
 * Assumes a 32-bit classic Wishbone slave with one register to each aligned word.
 */
`ifndef DPQ_REGS_SVH
`define DPQ_REGS_SVH

// Byte offsets of the register words.
`define DPQ_OFF_SUBCMD 8'h00
`define DPQ_OFF_COUNT 8'h04
`define DPQ_OFF_UNIT 8'h08
`define DPQ_OFF_OPCODE 8'h0C
`define DPQ_OFF_FAIL 8'h10
`define DPQ_OFF_STATE 8'h14
`define DPQ_OFF_CTRL 8'h18
`define DPQ_OFF_IDENT 8'h1C
`define DPQ_OFF_OVERLAY 8'h20

// Command codes.
`define DPQ_OP_CARD_CHECK 8'hD1
`define DPQ_OP_PT_FIRST 8'hD2
`define DPQ_OP_PT_LAST 8'hD4
`define DPQ_OP_POWER_QUERY 8'hE5
`define DPQ_OP_OVERLAY 8'hB1

// Overlay subcommands carried in subcommand_select.
`define DPQ_SUB_RESTORE 8'hC0
`define DPQ_SUB_FREEZE 8'hC1
`define DPQ_SUB_IDENTIFY 8'hC2
`define DPQ_SUB_SET 8'hC3

// Result codes of the power query and of the card check.
`define DPQ_RES_STANDBY 8'h00
`define DPQ_RES_IDLE 8'h80
`define DPQ_RES_ACTIVE 8'hFF
`define DPQ_RES_CARD 8'h55

// Field positions.
`define DPQ_ST_BUSY 7
`define DPQ_ST_READY 6
`define DPQ_ST_FAULT 5
`define DPQ_ST_DREQ 3
`define DPQ_ST_ERR 0
`define DPQ_ERR_ABORT 2
`define DPQ_UNIT_DEV 4
`define DPQ_SUB_ENABLE 0
`define DPQ_IDENT_PT 3
`define DPQ_CTRL_PM 0
`define DPQ_CTRL_DCO 1
`define DPQ_CTRL_PT 2
`define DPQ_CTRL_PM_CANNOT 3
`define DPQ_CTRL_SOFT_RESET 7

// Reset values.
`define DPQ_CTRL_RESET 8'h07
`define DPQ_STATE_RESET 8'h40

`endif

/* File: include/dpq_pkg.sv */
/*
 * Types of the disk power query and configuration restore block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dpq_pkg;
    // Power mode reported by the drive's power manager.
    typedef enum logic [1:0] {
        DPQ_MODE_STANDBY = 2'h0,
        DPQ_MODE_IDLE = 2'h1,
        DPQ_MODE_ACTIVE = 2'h2,
        DPQ_MODE_ACTIVE_OR_IDLE = 2'h3
    } dpq_pmode_type;

    // Command sequencer states.
    typedef enum logic {
        DPQ_IDLE,
        DPQ_EXEC
    } dpq_state_type;
endpackage : dpq_pkg

/* File: hdl/dpq_sync.sv */
/*
 * Three-flop synchroniser for a group of level inputs.
 * Assumes the inputs are slow levels from outside the clock's domain.
 */
`timescale 1ns/100ps
`default_nettype none

module dpq_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    // Chain of three flops; the first one feeds only the second.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // A bit only moves once the second and third flops agree, filtering one-cycle glitches.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_out <= '0;
        end else begin
            sync_out <= (stage2_reg & ~(stage2_reg ^ stage3_reg)) | (sync_out & (stage2_reg ^ stage3_reg));
        end
    end
endmodule : dpq_sync

`default_nettype wire

/* File: hdl/dpq_core.sv */
/*
 * Command interpreter of a disk-style device: media-card type check and
 * pass-through gating, power mode query, configuration overlay dispatch and restore.
 * Assumes a classic Wishbone master on the same clock, and power manager,
 * fault and hardware reset levels that arrive asynchronously on pins.
 */
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "dpq_regs.svh"

// Behaviour
// - successful card check with enable sets word87 bit3
// - enabled pass-through commands are accepted and processed
// - disabled enable means D2-D4 are not pass-through
// - opcode E5h is the power mode query
// - query result 00h, 80h or FFh in count
// - query leaves power state and standby timer alone
// - no power management means query aborts
// - normal completion clears busy, fault, request, error; ready
// - error flag follows error bits; fault only on fault
// - device select bit reflects the selected unit
// - B1h dispatches overlay subcommand by subcommand value
// - restore aborts if unsupported, protected area, or frozen
// - successful restore cancels all overlay reductions
// - query may abort when action cannot be done
// - every reset disables pass-through
// - freeze lock survives hardware and software reset
module dpq_core (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire dpq_pkg::dpq_pmode_type power_mode_pin,
    input wire logic device_fault_pin,
    input wire logic hpa_active_pin,
    input wire logic hard_reset_pin,
    output logic pt_enabled_o,
    output logic overlay_reduced_o,
    output logic pt_cmd_pulse_o,
    output logic [7:0] pt_opcode_o
);
    import dpq_pkg::*;

    logic [4:0] pins_sync;
    dpq_pmode_type mode_now;
    logic fault_now;
    logic hpa_now;
    logic hard_reset_now;
    logic [7:0] subcmd_reg;
    logic [7:0] count_reg;
    logic [7:0] unit_reg;
    logic [7:0] opcode_reg;
    logic [7:0] fail_reg;
    logic [7:0] state_reg;
    logic [7:0] ctrl_reg;
    logic freeze_reg;
    logic soft_reset_reg;
    dpq_state_type seq_reg;
    logic bus_req;
    logic wr_fire;
    logic pt_reset;
    logic exec;
    logic abort_next;
    logic load_count;
    logic [7:0] count_next;
    logic pt_en_load;
    logic pt_start;
    logic freeze_set;
    logic reduce_set;
    logic reduce_clr;

    // Mode result of the power query.
    function automatic logic [7:0] mode_result(input dpq_pmode_type mode);
        case (mode)
            DPQ_MODE_STANDBY: mode_result = `DPQ_RES_STANDBY;
            DPQ_MODE_IDLE: mode_result = `DPQ_RES_IDLE;
            default: mode_result = `DPQ_RES_ACTIVE;
        endcase
    endfunction : mode_result

    // Pin levels cross into the clock domain through three flops.
    dpq_sync #(.WIDTH(5)) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in({power_mode_pin, device_fault_pin, hpa_active_pin, hard_reset_pin}),
        .sync_out(pins_sync)
    );

    assign mode_now = dpq_pmode_type'(pins_sync[4:3]);
    assign fault_now = pins_sync[2];
    assign hpa_now = pins_sync[1];
    assign hard_reset_now = pins_sync[0];
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign wr_fire = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
    assign exec = (seq_reg == DPQ_EXEC);
    assign pt_reset = hard_reset_now | soft_reset_reg;

    // Ack one cycle after the request; writes land at the acked edge the master samples.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            case (wb_adr_i)
                `DPQ_OFF_COUNT: wb_dat_o <= {24'h00_0000, count_reg};
                `DPQ_OFF_UNIT: wb_dat_o <= {24'h00_0000, unit_reg};
                `DPQ_OFF_FAIL: wb_dat_o <= {24'h00_0000, fail_reg};
                `DPQ_OFF_STATE: wb_dat_o <= {24'h00_0000, state_reg};
                `DPQ_OFF_CTRL: wb_dat_o <= {24'h00_0000, ctrl_reg};
                `DPQ_OFF_IDENT: wb_dat_o <= {28'h000_0000, pt_enabled_o, 3'h0};
                `DPQ_OFF_OVERLAY: wb_dat_o <= {30'h0, overlay_reduced_o, freeze_reg};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Host-written parameter registers; a command in flight freezes them.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            subcmd_reg <= 8'h00;
            unit_reg <= 8'h00;
            ctrl_reg <= `DPQ_CTRL_RESET;
        end else if (wr_fire && !state_reg[`DPQ_ST_BUSY]) begin
            if (wb_adr_i == `DPQ_OFF_SUBCMD) begin
                subcmd_reg <= wb_dat_i[7:0];
            end
            if (wb_adr_i == `DPQ_OFF_UNIT) begin
                unit_reg <= wb_dat_i[7:0];
            end
            if (wb_adr_i == `DPQ_OFF_CTRL) begin
                ctrl_reg <= {1'b0, wb_dat_i[6:0]};
            end
        end
    end

    // Software reset is a write-one pulse, kept one cycle wide.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            soft_reset_reg <= 1'b0;
        end else begin
            soft_reset_reg <= wr_fire && (wb_adr_i == `DPQ_OFF_CTRL) && wb_dat_i[`DPQ_CTRL_SOFT_RESET];
        end
    end

    // Opcode write starts a one-cycle execution; writes while busy are ignored.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seq_reg <= DPQ_IDLE;
            opcode_reg <= 8'h00;
        end else begin
            case (seq_reg)
                DPQ_IDLE: begin
                    if (wr_fire && wb_adr_i == `DPQ_OFF_OPCODE) begin
                        opcode_reg <= wb_dat_i[7:0];
                        seq_reg <= DPQ_EXEC;
                    end
                end
                DPQ_EXEC: seq_reg <= DPQ_IDLE;
                default: seq_reg <= DPQ_IDLE;
            endcase
        end
    end

    // Decode the command; a device fault turns any outcome into an abort.
    always_comb begin
        abort_next = 1'b0;
        load_count = 1'b0;
        count_next = 8'h00;
        pt_en_load = 1'b0;
        pt_start = 1'b0;
        freeze_set = 1'b0;
        reduce_set = 1'b0;
        reduce_clr = 1'b0;
        if (opcode_reg == `DPQ_OP_CARD_CHECK) begin
            if (!ctrl_reg[`DPQ_CTRL_PT]) begin
                abort_next = 1'b1;
            end else begin
                load_count = 1'b1;
                count_next = `DPQ_RES_CARD;
                pt_en_load = 1'b1;
            end
        end else if (opcode_reg >= `DPQ_OP_PT_FIRST && opcode_reg <= `DPQ_OP_PT_LAST) begin
            if (ctrl_reg[`DPQ_CTRL_PT] && pt_enabled_o) begin
                pt_start = 1'b1;
            end else begin
                abort_next = 1'b1;
            end
        end else if (opcode_reg == `DPQ_OP_POWER_QUERY) begin
            if (!ctrl_reg[`DPQ_CTRL_PM] || ctrl_reg[`DPQ_CTRL_PM_CANNOT]) begin
                abort_next = 1'b1;
            end else begin
                load_count = 1'b1;
                count_next = mode_result(mode_now);
            end
        end else if (opcode_reg == `DPQ_OP_OVERLAY) begin
            if (!ctrl_reg[`DPQ_CTRL_DCO]) begin
                abort_next = 1'b1;
            end else begin
                case (subcmd_reg)
                    `DPQ_SUB_RESTORE: begin
                        abort_next = hpa_now | freeze_reg;
                        reduce_clr = ~(hpa_now | freeze_reg);
                    end
                    `DPQ_SUB_FREEZE: begin
                        abort_next = freeze_reg;
                        freeze_set = ~freeze_reg;
                    end
                    `DPQ_SUB_IDENTIFY: abort_next = freeze_reg;
                    `DPQ_SUB_SET: begin
                        abort_next = freeze_reg;
                        reduce_set = ~freeze_reg;
                    end
                    default: abort_next = 1'b1;
                endcase
            end
        end else begin
            abort_next = 1'b1;
        end
        if (fault_now) begin
            abort_next = 1'b1;
            load_count = 1'b0;
            pt_en_load = 1'b0;
            pt_start = 1'b0;
            freeze_set = 1'b0;
            reduce_set = 1'b0;
            reduce_clr = 1'b0;
        end
    end

    // Completion: status, error cause and result count.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= `DPQ_STATE_RESET;
            fail_reg <= 8'h00;
            count_reg <= 8'h00;
        end else if (wr_fire && wb_adr_i == `DPQ_OFF_OPCODE && !exec) begin
            state_reg <= 8'h80;
        end else if (exec) begin
            state_reg <= 8'h00;
            state_reg[`DPQ_ST_READY] <= 1'b1;
            state_reg[`DPQ_ST_ERR] <= abort_next;
            state_reg[`DPQ_ST_FAULT] <= abort_next & fault_now;
            fail_reg <= 8'h00;
            fail_reg[`DPQ_ERR_ABORT] <= abort_next;
            if (load_count) begin
                count_reg <= count_next;
            end
        end else if (wr_fire && wb_adr_i == `DPQ_OFF_COUNT) begin
            count_reg <= wb_dat_i[7:0];
        end
    end

    // Pass-through enable; any reset clears it and the reset wins.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pt_enabled_o <= 1'b0;
        end else if (pt_reset) begin
            pt_enabled_o <= 1'b0;
        end else if (exec && pt_en_load) begin
            pt_enabled_o <= subcmd_reg[`DPQ_SUB_ENABLE];
        end
    end

    // Pass-through start strobe to the card engine; pass-through opcodes sent while disabled abort and never strobe.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pt_cmd_pulse_o <= 1'b0;
            pt_opcode_o <= 8'h00;
        end else begin
            pt_cmd_pulse_o <= exec & pt_start;
            if (exec && pt_start) begin
                pt_opcode_o <= opcode_reg;
            end
        end
    end

    // Overlay state; only power-up clears the freeze, so hard or soft reset never touch it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            freeze_reg <= 1'b0;
            overlay_reduced_o <= 1'b0;
        end else if (exec) begin
            if (freeze_set) begin
                freeze_reg <= 1'b1;
            end
            if (reduce_clr) begin
                overlay_reduced_o <= 1'b0;
            end else if (reduce_set) begin
                overlay_reduced_o <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Checks on completion and command effects.
    property p_done_flags;
        exec && !abort_next |=> !state_reg[`DPQ_ST_BUSY] && state_reg[`DPQ_ST_READY] && state_reg == 8'h40;
    endproperty
    a_done_flags: assert property (p_done_flags) else $error("normal completion flags wrong");
    property p_err_follows;
        exec |=> state_reg[`DPQ_ST_ERR] == (fail_reg != 8'h00) && state_reg[`DPQ_ST_FAULT] == $past(fault_now);
    endproperty
    a_err_follows: assert property (p_err_follows) else $error("error flag disagrees with cause");
    property p_query_result;
        exec && opcode_reg == `DPQ_OP_POWER_QUERY && !abort_next |=> count_reg == mode_result($past(mode_now));
    endproperty
    a_query_result: assert property (p_query_result) else $error("power query result wrong");
    property p_query_unsup;
        exec && opcode_reg == `DPQ_OP_POWER_QUERY && !ctrl_reg[`DPQ_CTRL_PM] |=> fail_reg[`DPQ_ERR_ABORT];
    endproperty
    a_query_unsup: assert property (p_query_unsup) else $error("query without power management not aborted");
    property p_pt_blocked;
        exec && opcode_reg >= `DPQ_OP_PT_FIRST && opcode_reg <= `DPQ_OP_PT_LAST && !pt_enabled_o
            |=> fail_reg[`DPQ_ERR_ABORT] && !pt_cmd_pulse_o;
    endproperty
    a_pt_blocked: assert property (p_pt_blocked) else $error("pass-through ran while disabled");
    property p_pt_runs;
        exec && pt_start |=> pt_cmd_pulse_o && pt_opcode_o == $past(opcode_reg) ##1 !pt_cmd_pulse_o;
    endproperty
    a_pt_runs: assert property (p_pt_runs) else $error("pass-through strobe wrong");
    property p_ident_bit;
        exec && pt_en_load && !pt_reset |=> pt_enabled_o == $past(subcmd_reg[`DPQ_SUB_ENABLE]);
    endproperty
    a_ident_bit: assert property (p_ident_bit) else $error("identity bit not following enable");
    property p_restore_guard;
        exec && opcode_reg == `DPQ_OP_OVERLAY && subcmd_reg == `DPQ_SUB_RESTORE && (hpa_now || freeze_reg)
            |=> fail_reg[`DPQ_ERR_ABORT] && $stable(overlay_reduced_o);
    endproperty
    a_restore_guard: assert property (p_restore_guard) else $error("blocked restore not aborted");
    property p_restore_clear;
        exec && reduce_clr |=> !overlay_reduced_o && !state_reg[`DPQ_ST_ERR];
    endproperty
    a_restore_clear: assert property (p_restore_clear) else $error("restore left a reduction");
    property p_reserved_sub;
        exec && opcode_reg == `DPQ_OP_OVERLAY && subcmd_reg < `DPQ_SUB_RESTORE |=> state_reg[`DPQ_ST_ERR];
    endproperty
    a_reserved_sub: assert property (p_reserved_sub) else $error("reserved subcommand accepted");
    property p_reset_pt;
        pt_reset |=> !pt_enabled_o;
    endproperty
    a_reset_pt: assert property (p_reset_pt) else $error("reset left pass-through on");
    property p_freeze_keep;
        freeze_reg |=> freeze_reg;
    endproperty
    a_freeze_keep: assert property (p_freeze_keep) else $error("freeze lock lost");
    property p_unit_kept;
        exec |=> $stable(unit_reg[`DPQ_UNIT_DEV]);
    endproperty
    a_unit_kept: assert property (p_unit_kept) else $error("device select changed by command");

    c_query: cover property (exec && opcode_reg == `DPQ_OP_POWER_QUERY && !abort_next);
    c_restore: cover property (exec && reduce_clr);
    c_pt: cover property (pt_cmd_pulse_o);
    c_freeze: cover property (exec && freeze_set);
endmodule : dpq_core

`default_nettype wire

/* File: test/dpq_env_model.sv */
/*
 * Model of the drive hardware around the command block: power manager,
 * fault sensor, protected-area flag and hardware reset line.
 * Assumes the bench sets wanted levels; the pins move on the falling edge,
 * so they arrive out of phase with the block's sampling edge.
 */
`timescale 1ns/100ps
`default_nettype none

module dpq_env_model (
    input wire logic clk,
    input wire dpq_pkg::dpq_pmode_type want_mode,
    input wire logic want_fault,
    input wire logic want_hpa,
    input wire logic want_hreset,
    output dpq_pkg::dpq_pmode_type power_mode_pin,
    output logic device_fault_pin,
    output logic hpa_active_pin,
    output logic hard_reset_pin
);
    import dpq_pkg::*;

    // power mode held
    // The mode only changes when the bench asks, so a query must see it steady.
    always_ff @(negedge clk) begin
        power_mode_pin <= want_mode;
        device_fault_pin <= want_fault;
        hpa_active_pin <= want_hpa;
        hard_reset_pin <= want_hreset;
    end
endmodule : dpq_env_model

`default_nettype wire

/* File: test/disk_power_query_config_restore_test.sv */
/*
 * Self-checking bench of the command block: reads are noted in a queue by the
 * driver and compared by a monitor when the acknowledge arrives.
 * Assumes the core, its package and register header, and the pin model.
 */
`timescale 1ns/100ps
`default_nettype none
`include "dpq_regs.svh"

module disk_power_query_config_restore_test;
    import dpq_pkg::*;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic ack, pt_en, ov_red, pt_pulse;
    logic [31:0] rdat;
    logic [7:0] pt_op;
    dpq_pmode_type want_mode = DPQ_MODE_STANDBY, pm_pin;
    logic want_fault = 0, want_hpa = 0, want_hreset = 0, flt_pin, hpa_pin, hr_pin;
    int failures = 0, num_checks = 0, i;
    logic [31:0] exp_q[$];
    string name_q[$];
    logic [7:0] pt_q[$];
    logic [7:0] mode_res [4] = '{8'h00, 8'h80, 8'hFF, 8'hFF};
    logic [7:0] rsv [4] = '{8'h00, 8'hBF, 8'hC4, 8'hFF};

    dpq_core i_dpq_core (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(rdat),
        .power_mode_pin(pm_pin), .device_fault_pin(flt_pin), .hpa_active_pin(hpa_pin),
        .hard_reset_pin(hr_pin), .pt_enabled_o(pt_en), .overlay_reduced_o(ov_red),
        .pt_cmd_pulse_o(pt_pulse), .pt_opcode_o(pt_op));
    dpq_env_model i_dpq_env_model (.clk(clk), .want_mode(want_mode), .want_fault(want_fault),
        .want_hpa(want_hpa), .want_hreset(want_hreset), .power_mode_pin(pm_pin),
        .device_fault_pin(flt_pin), .hpa_active_pin(hpa_pin), .hard_reset_pin(hr_pin));

    // Free-running 25 MHz clock.
    always #20 clk = ~clk;

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task give_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    // One classic cycle; the request stands until ack is sampled high.
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            give_verdict();
        end else begin
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
        end
    endtask : bus

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1, a, d);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] e, input string name);
        exp_q.push_back(e);
        name_q.push_back(name);
        bus(0, a, 32'h0);
    endtask : rd

    // Issue a command and read back its completion registers two cycles later.
    task run(input logic [7:0] op, input logic [7:0] st, input logic [7:0] er);
        wr(`DPQ_OFF_OPCODE, op);
        repeat (2) @(posedge clk);
        rd(`DPQ_OFF_STATE, st, "status");
        rd(`DPQ_OFF_FAIL, er, "error");
    endtask : run

    // Pins pass a synchroniser, so they are held well before the next command.
    task pins(input dpq_pmode_type m, input logic f, input logic h, input logic r);
        want_mode <= m;
        want_fault <= f;
        want_hpa <= h;
        want_hreset <= r;
        repeat (8) @(posedge clk);
    endtask : pins

    // Read results are compared in the order they were requested.
    always @(posedge clk) begin
        if (cyc && stb && !we && ack === 1'b1) begin
            check(name_q.pop_front(), rdat, exp_q.pop_front());
        end
    end

    // Every pass-through pulse must match a command that was expected to pass.
    always @(posedge clk) begin
        if (!rst && pt_pulse !== 1'b0) begin
            if (pt_q.size() == 0) check("pt_pulse", pt_pulse, 1'b0);
            else check("pt_opcode", pt_op, pt_q.pop_front());
        end
    end

    // A hang anywhere ends the run as a failure.
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        give_verdict();
    end

    initial begin
        void'($urandom(32'hAB9B4C87));
        repeat (16) @(posedge clk);
        rst <= 0;
        rd(`DPQ_OFF_CTRL, 8'h07, "ctrl");
        rd(`DPQ_OFF_STATE, 8'h40, "status");
        rd(`DPQ_OFF_IDENT, 8'h00, "ident");
        wr(8'h3C, 32'hFF);
        rd(8'h3C, 32'h0, "unmapped");
        wr(`DPQ_OFF_UNIT, 32'h10);
        for (i = 0; i < 4; i++) begin
            pins(dpq_pmode_type'(i[1:0]), 0, 0, 0);
            wr(`DPQ_OFF_COUNT, $urandom);
            run(`DPQ_OP_POWER_QUERY, 8'h40, 8'h00);
            rd(`DPQ_OFF_COUNT, mode_res[i], "count");
            rd(`DPQ_OFF_UNIT, 8'h10, "unit");
        end
        run(`DPQ_OP_POWER_QUERY, 8'h40, 8'h00);
        rd(`DPQ_OFF_COUNT, 8'hFF, "count");
        wr(`DPQ_OFF_CTRL, 8'h06);
        run(`DPQ_OP_POWER_QUERY, 8'h41, 8'h04);
        wr(`DPQ_OFF_CTRL, 8'h0F);
        run(`DPQ_OP_POWER_QUERY, 8'h41, 8'h04);
        wr(`DPQ_OFF_CTRL, 8'h07);
        pins(DPQ_MODE_ACTIVE, 1, 0, 0);
        run(`DPQ_OP_POWER_QUERY, 8'h61, 8'h04);
        pins(DPQ_MODE_ACTIVE, 0, 0, 0);
        wr(`DPQ_OFF_SUBCMD, 8'h00);
        run(`DPQ_OP_CARD_CHECK, 8'h40, 8'h00);
        run(`DPQ_OP_PT_FIRST, 8'h41, 8'h04);
        wr(`DPQ_OFF_SUBCMD, 8'h01);
        run(`DPQ_OP_CARD_CHECK, 8'h40, 8'h00);
        rd(`DPQ_OFF_COUNT, `DPQ_RES_CARD, "count");
        rd(`DPQ_OFF_IDENT, 8'h08, "ident");
        check("pt_en", pt_en, 1'b1);
        rd(`DPQ_OFF_SUBCMD, 8'h00, "subcmd");
        for (i = 8'hD2; i <= 8'hD4; i++) begin
            pt_q.push_back(i[7:0]);
            run(i[7:0], 8'h40, 8'h00);
        end
        wr(`DPQ_OFF_CTRL, 8'h87);
        rd(`DPQ_OFF_IDENT, 8'h00, "ident");
        check("pt_en", pt_en, 1'b0);
        run(8'hD3, 8'h41, 8'h04);
        run(`DPQ_OP_CARD_CHECK, 8'h40, 8'h00);
        pins(DPQ_MODE_ACTIVE, 0, 0, 1);
        pins(DPQ_MODE_ACTIVE, 0, 0, 0);
        rd(`DPQ_OFF_IDENT, 8'h00, "ident");
        wr(`DPQ_OFF_SUBCMD, `DPQ_SUB_SET);
        run(`DPQ_OP_OVERLAY, 8'h40, 8'h00);
        rd(`DPQ_OFF_OVERLAY, 8'h02, "overlay");
        check("ov_red", ov_red, 1'b1);
        wr(`DPQ_OFF_SUBCMD, `DPQ_SUB_RESTORE);
        run(`DPQ_OP_OVERLAY, 8'h40, 8'h00);
        rd(`DPQ_OFF_OVERLAY, 8'h00, "overlay");
        check("ov_red", ov_red, 1'b0);
        wr(`DPQ_OFF_SUBCMD, `DPQ_SUB_IDENTIFY);
        run(`DPQ_OP_OVERLAY, 8'h40, 8'h00);
        for (i = 0; i < 5; i++) begin
            wr(`DPQ_OFF_SUBCMD, (i < 4) ? rsv[i] : $urandom_range(8'hBF, 0));
            run(`DPQ_OP_OVERLAY, 8'h41, 8'h04);
        end
        pins(DPQ_MODE_ACTIVE, 0, 1, 0);
        wr(`DPQ_OFF_SUBCMD, `DPQ_SUB_RESTORE);
        run(`DPQ_OP_OVERLAY, 8'h41, 8'h04);
        pins(DPQ_MODE_ACTIVE, 0, 0, 0);
        wr(`DPQ_OFF_CTRL, 8'h05);
        run(`DPQ_OP_OVERLAY, 8'h41, 8'h04);
        wr(`DPQ_OFF_CTRL, 8'h07);
        wr(`DPQ_OFF_SUBCMD, `DPQ_SUB_FREEZE);
        run(`DPQ_OP_OVERLAY, 8'h40, 8'h00);
        wr(`DPQ_OFF_SUBCMD, `DPQ_SUB_RESTORE);
        run(`DPQ_OP_OVERLAY, 8'h41, 8'h04);
        wr(`DPQ_OFF_SUBCMD, `DPQ_SUB_SET);
        run(`DPQ_OP_OVERLAY, 8'h41, 8'h04);
        check("ov_red", ov_red, 1'b0);
        wr(`DPQ_OFF_CTRL, 8'h87);
        pins(DPQ_MODE_ACTIVE, 0, 0, 1);
        pins(DPQ_MODE_ACTIVE, 0, 0, 0);
        rd(`DPQ_OFF_OVERLAY, 8'h01, "overlay");
        @(posedge clk);
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        rd(`DPQ_OFF_OVERLAY, 8'h00, "overlay");
        rd(`DPQ_OFF_UNIT, 8'h00, "unit");
        repeat (4) @(posedge clk);
        check("pt_left", pt_q.size(), 0);
        check("reads_left", exp_q.size(), 0);
        give_verdict();
    end
endmodule : disk_power_query_config_restore_test

`default_nettype wire
